/* File: logic/hlt_pkg.sv */
// hlt_pkg: register map, field layout, reset values and timing for the limit timer
// assumes APB byte addressing with one 32-bit word per register
package hlt_pkg;
    // ==========================================================
    // register byte offsets
    localparam logic [7:0] ADDR_CTRL   = 8'h00;
    localparam logic [7:0] ADDR_LIMIT  = 8'h04;
    localparam logic [7:0] ADDR_RSTSRC = 8'h08;
    localparam logic [7:0] ADDR_COUNT  = 8'h0C;
    localparam logic [7:0] ADDR_PERIOD = 8'h10;
    localparam logic [7:0] ADDR_IRQ    = 8'h14;
    // ==========================================================
    // field layout
    localparam int CNT_W       = 8;
    localparam int PS_W        = 4;
    localparam int MODE_W      = 5;
    localparam int SRCSEL_W    = 5;
    localparam int CTRL_ON_BIT = 7;
    localparam int IRQ_FLAG    = 0;
    localparam int IRQ_EN      = 1;
    // ==========================================================
    // reset values
    localparam logic [CNT_W-1:0]    COUNT_RST  = 8'h00;
    localparam logic [CNT_W-1:0]    PERIOD_RST = 8'hFF;
    localparam logic [MODE_W-1:0]   MODE_RST   = 5'h00;
    localparam logic [PS_W-1:0]     PS_RST     = 4'h0;
    localparam logic [SRCSEL_W-1:0] SRCSEL_RST = 5'h00;
    // ==========================================================
    // mode groups in mode bits 4:3
    localparam logic [1:0] GRP_FREE    = 2'h0;
    localparam logic [1:0] GRP_ONESHOT = 2'h1;
    localparam logic [1:0] GRP_MONO    = 2'h2;
    // ==========================================================
    // timing: timer clock and the far side's trigger spacing
    localparam int TMR_CLK_NS       = 100;
    localparam int EDGE_GAP_CLKS    = 6;
    localparam int LEVEL_MIN_CLKS   = 3;
    typedef enum logic {RUN_WAIT, RUN_ACTIVE} hlt_run_t;
endpackage : hlt_pkg

/* File: logic/hlt_core_if.sv */
// hlt_core_if: signals between the timer core, trigger synchroniser and postscaler
// assumes all three parties run on core_clk
`timescale 1ns/100ps
interface hlt_core_if;
    logic                     freeze;
    logic [hlt_pkg::SRCSEL_W-1:0] srcSel;
    logic                     ersLevel;
    logic                     ersRise;
    logic                     ersFall;
    logic                     match;
    logic                     psClear;
    logic [hlt_pkg::PS_W-1:0] psSel;
    logic                     postPulse;
    modport core (output freeze, srcSel, match, psClear, psSel,
                  input ersLevel, ersRise, ersFall, postPulse);
    modport sync (input freeze, srcSel, output ersLevel, ersRise, ersFall);
    modport post (input match, psClear, psSel, output postPulse);
endinterface : hlt_core_if

/* File: logic/hlt_ers_sync.sv */
// hlt_ers_sync: selects the external reset source, synchronises it and finds its edges
// assumes sources are asynchronous to core_clk
`timescale 1ns/100ps
module hlt_ers_sync
    import hlt_pkg::*;
#(
    parameter int SRC_NUM = 32
) (
    input  wire logic               core_clk,
    input  wire logic               rst_n,
    input  wire logic [SRC_NUM-1:0] ersSources,
    hlt_core_if.sync                bus
);
    typedef struct packed {
        logic s1, s2, s3, lvl, rise, fall;
    } hlt_sync_st_t;
    localparam hlt_sync_st_t SYNC_RST = '0;
    hlt_sync_st_t st_ff, nxt_st;
    logic         selected;

    // ==========================================================
    // source select and filter
    assign selected = (int'(bus.srcSel) < SRC_NUM) ? ersSources[bus.srcSel] : 1'b0; // R1

    always_comb begin
        nxt_st = st_ff;
        nxt_st.s1 = selected;
        nxt_st.s2 = st_ff.s1;
        nxt_st.s3 = st_ff.s2;
        if (!bus.freeze && st_ff.s2 == st_ff.s3) begin // R5
            nxt_st.lvl = st_ff.s2;
        end
        nxt_st.rise = nxt_st.lvl & ~st_ff.lvl;
        nxt_st.fall = ~nxt_st.lvl & st_ff.lvl;
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) st_ff <= SYNC_RST;
        else st_ff <= nxt_st;
    end

    assign bus.ersLevel = st_ff.lvl;
    assign bus.ersRise  = st_ff.rise;
    assign bus.ersFall  = st_ff.fall;

    freeze_quiet_a: assert property (@(posedge core_clk) disable iff (!rst_n) // R5
        bus.freeze |=> !(st_ff.rise || st_ff.fall)) else $error("edge seen during freeze");
endmodule : hlt_ers_sync

/* File: logic/hlt_postscale.sv */
// hlt_postscale: counts period matches and pulses once per selected ratio
// assumes match and clear are one-cycle pulses from the core
`timescale 1ns/100ps
module hlt_postscale
    import hlt_pkg::*;
(
    input  wire logic core_clk,
    input  wire logic rst_n,
    hlt_core_if.post  bus
);
    typedef struct packed {
        logic [PS_W-1:0] cnt;
        logic            pulse;
    } hlt_ps_st_t;
    localparam hlt_ps_st_t PS_ST_RST = '0;
    hlt_ps_st_t st_ff, nxt_st;

    always_comb begin
        nxt_st = st_ff;
        nxt_st.pulse = 1'b0;
        if (bus.psClear) begin // R22
            nxt_st.cnt = '0;
        end else if (bus.match) begin
            if (st_ff.cnt == bus.psSel) begin // R18
                nxt_st.cnt = '0;
                nxt_st.pulse = 1'b1;
            end else begin
                nxt_st.cnt = st_ff.cnt + 1'b1;
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) st_ff <= PS_ST_RST;
        else st_ff <= nxt_st;
    end

    assign bus.postPulse = st_ff.pulse;

    ps_ratio_a: assert property (@(posedge core_clk) disable iff (!rst_n) // R18
        bus.match && !bus.psClear && st_ff.cnt == bus.psSel |=> st_ff.pulse && st_ff.cnt == '0)
        else $error("postscaler missed its ratio");
    ps_clear_a: assert property (@(posedge core_clk) disable iff (!rst_n) // R22
        bus.psClear |=> st_ff.cnt == '0 && !st_ff.pulse) else $error("postscaler not cleared");
endmodule : hlt_postscale

/* File: logic/hlt_timer.sv */
// hlt_timer: 8-bit period timer with hardware limit modes, APB register slave
// assumes an APB master on core_clk; trigger sources come from other logic
//
// Our own choices: register access over APB and the address map.
`timescale 1ns/100ps
// ==========================================================
// Contract
// R1 - reset source taken from selected input
// R2 - five-bit mode: group and option
// R3 - driver spaces trigger edges six clocks
// R4 - driver holds trigger level three clocks
// R5 - triggers ignored during debug freeze
// R6 - free modes gate by on, level
// R7 - free 011 clears on either edge
// R8 - free 100/101 clear on rise/fall
// R9 - free 110/111 hold reset by level
// R10 - one-shot 000 starts when on set
// R11 - one-shot 001-011 start on edges
// R12 - one-shot 100/101 start and clear edge
// R13 - one-shot 110/111 edge start, level reset
// R14 - one-shot match clears on, stops zero
// R15 - monostable match stops, on stays set
// R16 - group 10 110/111 level one-shot
// R17 - edge while off never starts
// R18 - flag set at postscale ratio
// R19 - enable passes flag to interrupt
// R20 - count wraps to zero after match
// R21 - reset clears count, period maximum
// R22 - scaler cleared by writes, hw reset
// R23 - reserved modes keep counter stopped
module hlt_timer
    import hlt_pkg::*;
#(
    parameter int SRC_NUM = 32
) (
    input  wire logic               core_clk,
    input  wire logic               rst_n,
    input  wire logic [7:0]         paddr,
    input  wire logic               psel,
    input  wire logic               penable,
    input  wire logic               pwrite,
    input  wire logic [31:0]        pwdata,
    output logic      [31:0]        prdata,
    output logic                    pready,
    output logic                    pslverr,
    input  wire logic [SRC_NUM-1:0] ersSources,
    input  wire logic               debugFreeze,
    output logic      [CNT_W-1:0]   countValue,
    output logic                    timerOn,
    output logic                    postscaledPulse,
    output logic                    periodIrq
);
    typedef struct packed {
        logic [CNT_W-1:0]    count;
        logic [CNT_W-1:0]    period;
        logic                on;
        logic [PS_W-1:0]     psSel;
        logic [MODE_W-1:0]   mode;
        logic [SRCSEL_W-1:0] srcSel;
        logic                flag;
        logic                irqEn;
        logic                irq;
        hlt_run_t            run;
        logic                match;
        logic                psClear;
        logic [31:0]         prdata;
    } hlt_core_st_t;

    typedef struct packed {
        logic canRun;
        logic hwRst;
        logic startEv;
    } hlt_ctl_t;

    localparam hlt_core_st_t CORE_RST = '{
        count: COUNT_RST, period: PERIOD_RST, on: 1'b0, psSel: PS_RST,
        mode: MODE_RST, srcSel: SRCSEL_RST, flag: 1'b0, irqEn: 1'b0,
        irq: 1'b0, run: RUN_WAIT, match: 1'b0, psClear: 1'b0, prdata: 32'h0000_0000};

    hlt_core_st_t st_ff, nxt_st;
    hlt_ctl_t     ctl;
    hlt_core_if   link ();
    logic         apbSetup;
    logic         apbWrite;
    logic         mapped;
    logic         isFree;
    logic         counting;
    logic         atMatch;
    logic [31:0]  rdData;

    // ==========================================================
    // sub-blocks
    hlt_ers_sync #(.SRC_NUM(SRC_NUM)) u_sync (
        .core_clk   (core_clk),
        .rst_n      (rst_n),
        .ersSources (ersSources),
        .bus        (link.sync)
    );

    hlt_postscale u_post (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .bus      (link.post)
    );

    assign link.freeze  = debugFreeze;
    assign link.srcSel  = st_ff.srcSel;
    assign link.match   = st_ff.match;
    assign link.psClear = st_ff.psClear;
    assign link.psSel   = st_ff.psSel;

    // ==========================================================
    // mode decode: run permission, hardware reset and start event
    function automatic hlt_ctl_t modeCtl(input logic [MODE_W-1:0] m, input logic lvl,
                                         input logic rise, input logic fall);
        hlt_ctl_t c;
        c = '0;
        unique case (m[4:3]) // R2
            GRP_FREE: begin
                c.startEv = 1'b1;
                unique case (m[2:0])
                    3'h0: c.canRun = 1'b1;                                    // R6
                    3'h1: c.canRun = lvl;                                     // R6
                    3'h2: c.canRun = ~lvl;                                    // R6
                    3'h3: begin c.canRun = 1'b1; c.hwRst = rise | fall; end   // R7
                    3'h4: begin c.canRun = 1'b1; c.hwRst = rise; end          // R8
                    3'h5: begin c.canRun = 1'b1; c.hwRst = fall; end          // R8
                    3'h6: begin c.canRun = lvl; c.hwRst = ~lvl; end           // R9
                    3'h7: begin c.canRun = ~lvl; c.hwRst = lvl; end           // R9
                endcase
            end
            GRP_ONESHOT: begin
                c.canRun = 1'b1;
                unique case (m[2:0])
                    3'h0: c.startEv = 1'b1;                                   // R10
                    3'h1: c.startEv = rise;                                   // R11
                    3'h2: c.startEv = fall;                                   // R11
                    3'h3: c.startEv = rise | fall;                            // R11
                    3'h4: begin c.startEv = rise; c.hwRst = rise; end         // R12
                    3'h5: begin c.startEv = fall; c.hwRst = fall; end         // R12
                    3'h6: begin c.startEv = rise; c.hwRst = ~lvl; end         // R13
                    3'h7: begin c.startEv = fall; c.hwRst = lvl; end          // R13
                endcase
            end
            GRP_MONO: begin
                unique case (m[2:0])
                    3'h1: begin c.canRun = 1'b1; c.startEv = rise; end        // R15
                    3'h2: begin c.canRun = 1'b1; c.startEv = fall; end        // R15
                    3'h3: begin c.canRun = 1'b1; c.startEv = rise | fall; end // R15
                    3'h6: begin c.canRun = lvl; c.startEv = lvl; c.hwRst = ~lvl; end  // R16
                    3'h7: begin c.canRun = ~lvl; c.startEv = ~lvl; c.hwRst = lvl; end // R16
                    default: c = '0;                                          // R23
                endcase
            end
            default: c = '0;                                                  // R23
        endcase
        return c;
    endfunction : modeCtl

    assign ctl = modeCtl(st_ff.mode, link.ersLevel, link.ersRise, link.ersFall);

    // ==========================================================
    // register read mux and decode
    always_comb begin
        rdData = 32'h0000_0000;
        mapped = 1'b1;
        unique case (paddr)
            ADDR_CTRL:   rdData = {24'h00_0000, st_ff.on, 3'h0, st_ff.psSel};
            ADDR_LIMIT:  rdData = {27'h000_0000, st_ff.mode};
            ADDR_RSTSRC: rdData = {27'h000_0000, st_ff.srcSel};
            ADDR_COUNT:  rdData = {24'h00_0000, st_ff.count};
            ADDR_PERIOD: rdData = {24'h00_0000, st_ff.period};
            ADDR_IRQ:    rdData = {30'h0000_0000, st_ff.irqEn, st_ff.flag};
            default:     mapped = 1'b0;
        endcase
    end

    assign apbSetup = psel & ~penable;
    assign apbWrite = psel & penable & pwrite & mapped;
    assign isFree   = (st_ff.mode[4:3] == GRP_FREE);
    assign counting = st_ff.on & ctl.canRun & (isFree | (st_ff.run == RUN_ACTIVE));
    assign atMatch  = counting & (st_ff.count == st_ff.period);

    // ==========================================================
    // next state
    always_comb begin
        nxt_st = st_ff;
        nxt_st.match = 1'b0;
        nxt_st.psClear = 1'b0;
        if (apbSetup && !pwrite) begin
            nxt_st.prdata = rdData;
        end
        if (!st_ff.on) begin
            nxt_st.run = RUN_WAIT;                                            // R17
        end else if (!isFree && st_ff.run == RUN_WAIT && ctl.startEv) begin
            nxt_st.run = RUN_ACTIVE;                                          // R10
        end
        if (st_ff.on && ctl.hwRst) begin
            nxt_st.count = '0;
            nxt_st.psClear = 1'b1;                                            // R22
        end else if (atMatch) begin
            nxt_st.count = '0;                                                // R20
            nxt_st.match = 1'b1;
            if (!isFree) begin
                nxt_st.run = RUN_WAIT;                                        // R15
            end
            if (st_ff.mode[4:3] == GRP_ONESHOT || (st_ff.mode[4:3] == GRP_MONO && st_ff.mode[2:1] == 2'h3)) begin
                nxt_st.on = 1'b0;                                             // R14
            end
        end else if (counting) begin
            nxt_st.count = st_ff.count + 1'b1;                                // R20
        end
        if (apbWrite) begin
            unique case (paddr)
                ADDR_CTRL: begin
                    nxt_st.on = pwdata[CTRL_ON_BIT];
                    nxt_st.psSel = pwdata[PS_W-1:0];
                    nxt_st.psClear = 1'b1;                                    // R22
                end
                ADDR_LIMIT:  nxt_st.mode = pwdata[MODE_W-1:0];                // R2
                ADDR_RSTSRC: nxt_st.srcSel = pwdata[SRCSEL_W-1:0];            // R1
                ADDR_COUNT: begin
                    nxt_st.count = pwdata[CNT_W-1:0];
                    nxt_st.psClear = 1'b1;                                    // R22
                end
                ADDR_PERIOD: nxt_st.period = pwdata[CNT_W-1:0];
                ADDR_IRQ: begin
                    nxt_st.irqEn = pwdata[IRQ_EN];                            // R19
                    if (pwdata[IRQ_FLAG]) begin
                        nxt_st.flag = 1'b0;
                    end
                end
                default: nxt_st.flag = st_ff.flag;
            endcase
        end
        if (link.postPulse) begin
            nxt_st.flag = 1'b1;                                               // R18
        end
        nxt_st.irq = nxt_st.flag & nxt_st.irqEn;                              // R19
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) st_ff <= CORE_RST;                                        // R21
        else st_ff <= nxt_st;
    end

    // ==========================================================
    // outputs
    assign prdata          = st_ff.prdata;
    assign pready          = 1'b1;
    assign pslverr         = psel & penable & ~mapped;
    assign countValue      = st_ff.count;
    assign timerOn         = st_ff.on;
    assign postscaledPulse = link.postPulse;
    assign periodIrq       = st_ff.irq;

    // ==========================================================
    // checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    logic wrCount;
    assign wrCount = apbWrite && paddr == ADDR_COUNT;

    reset_values_a: assert property ($rose(rst_n) |-> st_ff.count == COUNT_RST && st_ff.period == PERIOD_RST) // R21
        else $error("reset values wrong");
    count_wrap_a: assert property (atMatch && !ctl.hwRst && !wrCount |=> st_ff.count == '0 && st_ff.match) // R20
        else $error("count did not wrap at period");
    oneshot_stop_a: assert property (atMatch && st_ff.mode[4:3] == GRP_ONESHOT && !apbWrite // R14
        |=> !st_ff.on && st_ff.count == '0 ##1 st_ff.count == '0) else $error("one-shot did not stop");
    mono_keep_a: assert property (atMatch && st_ff.mode[4:3] == GRP_MONO && !st_ff.mode[2] && !apbWrite // R15
        |=> st_ff.on && st_ff.run == RUN_WAIT) else $error("monostable lost on bit");
    gate_hold_a: assert property (isFree && st_ff.mode[2:0] == 3'h1 && !link.ersLevel && !wrCount // R6
        |=> $stable(st_ff.count)) else $error("hardware gate leaked a count");
    level_reset_a: assert property (st_ff.on && isFree && st_ff.mode[2:0] == 3'h6 && !link.ersLevel // R9
        && !wrCount |=> st_ff.count == '0) else $error("low level reset not held");
    off_no_start_a: assert property (!st_ff.on && !isFree |=> st_ff.run == RUN_WAIT) // R17
        else $error("started while off");
    reserved_stop_a: assert property (st_ff.mode[4:3] == 2'h3 && !wrCount |=> $stable(st_ff.count)) // R23
        else $error("reserved mode counted");
    flag_set_a: assert property (link.postPulse |=> st_ff.flag && (st_ff.irq == st_ff.irqEn)) // R18
        else $error("flag not set by postscaler");
    irq_gate_a: assert property (!st_ff.irqEn |-> !periodIrq) // R19
        else $error("interrupt passed while disabled");

    oneshot_end_c: cover property (atMatch && st_ff.mode[4:3] == GRP_ONESHOT);
    mono_restart_c: cover property (st_ff.mode[4:3] == GRP_MONO && st_ff.match ##[1:300] counting);
    hw_reset_c: cover property (st_ff.on && ctl.hwRst && st_ff.count != '0);
    post_pulse_c: cover property (link.postPulse && st_ff.psSel != '0);
endmodule : hlt_timer

/* File: testbench/hlt_ers_drv.sv */
// hlt_ers_drv: far-side driver of the external reset signal
// assumes bench requests on core_clk; unselected lines toggle every cycle
`timescale 1ns/100ps
module hlt_ers_drv (
    input  wire logic        core_clk,
    input  wire logic        rst_n,
    input  wire logic        wantLvl,
    input  wire logic [4:0]  srcIdx,
    output logic      [31:0] ersSources
);
    logic       lvl_ff;
    logic       tgl_ff;
    logic [3:0] gap_ff;
    // ==========================================================
    // level follows the request, seven clocks after the last change at the soonest
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            lvl_ff <= 1'b0;
            tgl_ff <= 1'b0;
            gap_ff <= 4'h0;
        end else begin
            tgl_ff <= ~tgl_ff;
            if (wantLvl != lvl_ff && gap_ff >= 4'h6) begin
                lvl_ff <= wantLvl;
                gap_ff <= 4'h0;
            end else if (gap_ff != 4'hF) begin
                gap_ff <= gap_ff + 4'h1;
            end
        end
    end
    always_comb begin
        ersSources         = {32{tgl_ff}};
        ersSources[srcIdx] = lvl_ff;
    end
endmodule : hlt_ers_drv

/* File: testbench/tb_period_timer_hw_limit_modes.sv */
// tb_period_timer_hw_limit_modes: self-checking bench for the limit timer
// assumes hlt_timer as APB slave and hlt_ers_drv as the trigger source
`timescale 1ns/100ps
module tb_period_timer_hw_limit_modes;
    import hlt_pkg::*;
    logic        core_clk    = 1'b0;
    logic        rst_n       = 1'b0;
    logic [7:0]  paddr       = 8'h00;
    logic        psel        = 1'b0;
    logic        penable     = 1'b0;
    logic        pwrite      = 1'b0;
    logic [31:0] pwdata      = 32'h0;
    logic        debugFreeze = 1'b0;
    logic        wantLvl     = 1'b0;
    logic [4:0]  src         = 5'h00;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [31:0] ersSources;
    logic [7:0]  countValue;
    logic        timerOn;
    logic        postscaledPulse;
    logic        periodIrq;
    logic [31:0] rdat;
    logic        rerr;
    logic [7:0]  maxCnt;
    logic [5:0]  eModes[12] = '{6'h09, 6'h0A, 6'h0B, 6'h0C, 6'h0D, 6'h0E, 6'h0F, 6'h31, 6'h32, 6'h33, 6'h16, 6'h17};
    logic [4:0]  rModes[5]  = '{5'h18, 5'h1F, 5'h10, 5'h14, 5'h15};
    int          seed            = 8916;
    int          bad_count       = 0;
    int          samples_checked = 0;
    int          gap;
    int          p;
    int          r;
    hlt_timer #(.SRC_NUM(32)) i_dut (.core_clk(core_clk), .rst_n(rst_n), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .ersSources(ersSources), .debugFreeze(debugFreeze), .countValue(countValue),
        .timerOn(timerOn), .postscaledPulse(postscaledPulse), .periodIrq(periodIrq));
    hlt_ers_drv i_drv (.core_clk(core_clk), .rst_n(rst_n), .wantLvl(wantLvl), .srcIdx(src), .ersSources(ersSources));
    always #50 core_clk = ~core_clk;
    // ==========================================================
    // helpers
    function automatic int expGap(input int per, input int ps);
        return (per + 1) * (ps + 1);
    endfunction : expGap
    // free modes: count after 30 clocks and one rise/fall pair on the trigger
    function automatic logic [31:0] expFree(input int code);
        case (code)
            2:       return 32'h29;
            4:       return 32'h11;
            7:       return 32'h6;
            default: return 32'h5;
        endcase
    endfunction : expFree
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch %s expected %0h seen %0h", what, exp, got);
        end
    endtask : chk
    task automatic cy(input int n);
        repeat (n) begin
            @(posedge core_clk);
            if (countValue > maxCnt) maxCnt = countValue;
        end
    endtask : cy
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        paddr   <= a;
        pwrite  <= w;
        pwdata  <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        do begin
            @(posedge core_clk);
        end while (pready !== 1'b1);
        rdat = prdata;
        rerr = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic setup(input logic [4:0] mode, input logic [7:0] per);
        apb(1'b1, ADDR_CTRL, 32'h0);
        apb(1'b1, ADDR_COUNT, 32'h0);
        apb(1'b1, ADDR_PERIOD, {24'h0, per});
        apb(1'b1, ADDR_LIMIT, {27'h0, mode});
        apb(1'b1, ADDR_RSTSRC, {27'h0, src});
        maxCnt = 8'h00;
    endtask : setup
    task automatic turnOn(input logic [3:0] ps);
        apb(1'b1, ADDR_CTRL, {24'h0, 4'h8, ps});
    endtask : turnOn
    task automatic waitPulse(output int n);
        n = 0;
        do begin
            cy(1);
            n++;
        end while (postscaledPulse !== 1'b1);
    endtask : waitPulse
    // one edge each way on the selected line
    task automatic pair2();
        wantLvl <= ~wantLvl;
        cy(12);
        wantLvl <= ~wantLvl;
        cy(12);
    endtask : pair2
    task automatic finish_test();
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : finish_test
    initial begin
        #(100 * 30000);
        bad_count++;
        finish_test();
    end
    // ==========================================================
    // tests
    initial begin
        repeat (20) @(posedge core_clk);
        rst_n <= 1'b1;
        apb(1'b0, ADDR_PERIOD, 32'h0);
        chk("period reset", 32'hFF, rdat);
        apb(1'b0, ADDR_COUNT, 32'h0);
        chk("count reset", 32'h0, rdat);
        apb(1'b0, 8'h40, 32'h0);
        chk("unmapped err", 32'h1, {31'h0, rerr});
        $display("test reset done");
        for (int i = 0; i < 4; i++) begin
            p = 2 + ($random(seed) & 7);
            r = (i == 3) ? 15 : ($random(seed) & 3);
            setup(5'h00, p[7:0]);
            turnOn(r[3:0]);
            waitPulse(gap);
            waitPulse(gap);
            chk("period gap", expGap(p, r), gap);
            chk("count max", 32'(p), {24'h0, maxCnt});
        end
        apb(1'b0, ADDR_IRQ, 32'h0);
        chk("flag set", 32'h1, rdat);
        chk("irq masked", 32'h0, {31'h0, periodIrq});
        apb(1'b1, ADDR_IRQ, 32'h3);
        waitPulse(gap);
        cy(3);
        chk("irq passed", 32'h1, {31'h0, periodIrq});
        apb(1'b1, ADDR_CTRL, 32'h0);
        apb(1'b1, ADDR_IRQ, 32'h1);
        cy(2);
        chk("irq cleared", 32'h0, {31'h0, periodIrq});
        $display("test period done");
        setup(5'h00, 8'hFF);
        turnOn(4'h0);
        cy(30);
        apb(1'b1, ADDR_CTRL, 32'h80);
        chk("ctrl keeps count", 32'h1, {31'h0, countValue >= 8'd30});
        setup(5'h08, 8'h04);
        turnOn(4'h0);
        cy(20);
        chk("oneshot on", 32'h0, {31'h0, timerOn});
        chk("oneshot max", 32'h4, {24'h0, maxCnt});
        src <= 5'($random(seed));
        setup(5'h01, 8'hFF);
        turnOn(4'h0);
        cy(12);
        chk("gate low", 32'h0, {24'h0, countValue});
        wantLvl <= 1'b1;
        cy(20);
        chk("gate high", 32'h1, {31'h0, countValue != 8'h00});
        setup(5'h06, 8'hFF);
        turnOn(4'h0);
        wantLvl <= 1'b0;
        cy(20);
        chk("level reset", 32'h0, {24'h0, countValue});
        for (int m = 2; m < 8; m++) begin
            if (m != 6) begin
                setup(5'(m), 8'hFF);
                turnOn(4'h0);
                cy(30);
                pair2();
                chk("free edge", expFree(m), {24'h0, countValue});
            end
        end
        $display("test free done");
        foreach (eModes[i]) begin
            setup(eModes[i][4:0], 8'h05);
            turnOn(4'h0);
            pair2();
            cy(13);
            chk("edge max", 32'h5, {24'h0, maxCnt});
            chk("edge on", {31'h0, eModes[i][5]}, {31'h0, timerOn});
            chk("edge count", 32'h0, {24'h0, countValue});
        end
        setup(5'h09, 8'h05);
        turnOn(4'h0);
        debugFreeze <= 1'b1;
        pair2();
        debugFreeze <= 1'b0;
        cy(12);
        chk("freeze count", 32'h0, {24'h0, countValue});
        chk("freeze on", 32'h1, {31'h0, timerOn});
        setup(5'h09, 8'h05);
        pair2();
        turnOn(4'h0);
        cy(12);
        chk("stale edge", 32'h0, {24'h0, countValue});
        chk("stale on", 32'h1, {31'h0, timerOn});
        foreach (rModes[i]) begin
            setup(rModes[i], 8'hFF);
            turnOn(4'h0);
            pair2();
            chk("reserved count", 32'h0, {24'h0, countValue});
        end
        $display("test trigger done");
        finish_test();
    end
endmodule : tb_period_timer_hw_limit_modes
